//--- hdl/uap_pkg.sv
// Constants, control struct and state encodings for the async serial port
package uap_pkg;

    // Data width and last data bit index
    localparam int unsigned DATA_W   = 8;
    localparam logic [2:0]  LAST_BIT = 3'h7;

    // Baud timer values
    localparam logic [7:0] TMR_RST = 8'h00;
    localparam logic [7:0] TMR_TOP = 8'hFF;
    localparam logic [5:0] PRE_RST = 6'h00;

    // Prescaler divisors for the baud timer clock sources
    localparam logic [5:0] DIV_SYS = 6'h01;
    localparam logic [5:0] DIV_4   = 6'h04;
    localparam logic [5:0] DIV_12  = 6'h0C;
    localparam logic [5:0] DIV_48  = 6'h30;
    localparam logic [5:0] DIV_OSC = 6'h08;
    localparam logic [5:0] DIV_EXT = 6'h01;

    // Reset values and full buffer count
    localparam logic [2:0] SYNC_HI_RST = 3'h7;
    localparam logic [2:0] SYNC_LO_RST = 3'h0;
    localparam logic [1:0] CNT_RST     = 2'h0;
    localparam logic [1:0] BUF_FULL    = 2'h2;
    localparam logic [2:0] BIT_RST     = 3'h0;

    // Baud timer clock source select
    typedef enum logic [2:0] {
        CSEL_SYS  = 3'h0,
        CSEL_DIV4 = 3'h1,
        CSEL_DIV12 = 3'h2,
        CSEL_DIV48 = 3'h3,
        CSEL_OSC8 = 3'h4,
        CSEL_EXT  = 3'h5
    } uap_csel_t;

    // Software control bits
    typedef struct packed {
        logic word_length_select;
        logic multiproc_enable_bit;
        logic rx_enable_bit;
        logic tx_ninth_bit;
    } uap_ctrl_t;

    // Frame phase, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_DATA  = 5'h04,
        ST_NINTH = 5'h08,
        ST_STOP  = 5'h10
    } uap_state_t;

endpackage

//--- hdl/uap_serial_port.sv
// Full-duplex async serial port with 8/9-bit frames and baud timer
`timescale 1ns/1ps

module uap_serial_port (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 clk_en,
    // Control bits
    input  wire uap_pkg::uap_ctrl_t   ctrl,
    input  wire logic                 port_irq_enable,
    input  wire logic                 tx_done_clr,
    input  wire logic                 rx_done_clr,
    // Baud timer setup and clock pins
    input  wire logic                 timer_enable,
    input  wire logic [7:0]           baud_reload_value,
    input  wire uap_pkg::uap_csel_t   clk_sel,
    input  wire logic                 ext_osc_pin,
    input  wire logic                 baud_timer_ext_input,
    // Data buffer write side
    input  wire logic                 tx_wr_valid,
    input  wire logic [7:0]           tx_wr_data,
    output logic                      tx_wr_ready,
    // Data buffer read side and flags
    output logic [7:0]                serial_data_buffer,
    output logic                      rx_ninth_bit,
    output logic                      tx_done_flag,
    output logic                      rx_done_flag,
    output logic                      port_irq,
    output logic [7:0]                baud_timer_low_byte,
    // Serial pins
    input  wire logic                 serial_in_pin,
    output logic                      serial_out_pin
);

    // Pin synchronisers: bit0 first stage, bit1 second, bit2 delayed copy
    logic [2:0] rx_sync_q, rx_sync_d;
    logic [2:0] osc_sync_q, osc_sync_d;
    logic [2:0] ext_sync_q, ext_sync_d;

    always_comb
    begin
        rx_sync_d  = {rx_sync_q[1:0], serial_in_pin};
        osc_sync_d = {osc_sync_q[1:0], ext_osc_pin};
        ext_sync_d = {ext_sync_q[1:0], baud_timer_ext_input};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_sync_q  <= uap_pkg::SYNC_HI_RST;
            osc_sync_q <= uap_pkg::SYNC_LO_RST;
            ext_sync_q <= uap_pkg::SYNC_LO_RST;
        end
        else if (clk_en)
        begin
            rx_sync_q  <= rx_sync_d;
            osc_sync_q <= osc_sync_d;
            ext_sync_q <= ext_sync_d;
        end
    end

    logic rx_bit;
    logic rx_start_seen;
    uap_pkg::uap_state_t rx_state_q, rx_state_d;

    assign rx_bit = rx_sync_q[1];
    assign rx_start_seen = rx_sync_q[2] & ~rx_sync_q[1]
                           & (rx_state_q == uap_pkg::ST_IDLE) & ctrl.rx_enable_bit;

    // Baud timer: prescaler, TX low byte, private RX copy
    logic [5:0] presc_q, presc_d;
    logic [7:0] tx_tmr_q, tx_tmr_d;
    logic [7:0] rx_tmr_q, rx_tmr_d;
    logic       tx_half_q, tx_half_d;
    logic       rx_half_q, rx_half_d;
    logic [5:0] div;
    logic       src_pulse;
    logic       tick;
    logic       tx_ovf;
    logic       rx_ovf;
    logic       tx_bit_tick;
    logic       rx_sample;

    always_comb
    begin
        unique case (clk_sel)
            uap_pkg::CSEL_SYS:   begin src_pulse = 1'b1; div = uap_pkg::DIV_SYS; end
            uap_pkg::CSEL_DIV4:  begin src_pulse = 1'b1; div = uap_pkg::DIV_4; end
            uap_pkg::CSEL_DIV12: begin src_pulse = 1'b1; div = uap_pkg::DIV_12; end
            uap_pkg::CSEL_DIV48: begin src_pulse = 1'b1; div = uap_pkg::DIV_48; end
            uap_pkg::CSEL_OSC8:
            begin
                src_pulse = osc_sync_q[1] & ~osc_sync_q[2];
                div       = uap_pkg::DIV_OSC;
            end
            uap_pkg::CSEL_EXT:
            begin
                src_pulse = ext_sync_q[2] & ~ext_sync_q[1];
                div       = uap_pkg::DIV_EXT;
            end
            default:             begin src_pulse = 1'b1; div = uap_pkg::DIV_SYS; end
        endcase
        presc_d = presc_q;
        tick    = 1'b0;
        if (timer_enable && src_pulse)
        begin
            if (presc_q >= div - 6'h01)
            begin
                presc_d = uap_pkg::PRE_RST;
                tick    = 1'b1;
            end
            else
            begin
                presc_d = presc_q + 6'h01;
            end
        end
        tx_tmr_d = tx_tmr_q;
        tx_ovf   = 1'b0;
        if (tick)
        begin
            if (tx_tmr_q == uap_pkg::TMR_TOP)
            begin
                tx_tmr_d = baud_reload_value;
                tx_ovf   = 1'b1;
            end
            else
            begin
                tx_tmr_d = tx_tmr_q + 8'h01;
            end
        end
        // RX copy, forced reload on start
        rx_tmr_d = rx_tmr_q;
        rx_ovf   = 1'b0;
        if (rx_start_seen)
        begin
            rx_tmr_d = baud_reload_value;
        end
        else if (tick)
        begin
            if (rx_tmr_q == uap_pkg::TMR_TOP)
            begin
                rx_tmr_d = baud_reload_value;
                rx_ovf   = 1'b1;
            end
            else
            begin
                rx_tmr_d = rx_tmr_q + 8'h01;
            end
        end
        tx_half_d   = tx_half_q ^ tx_ovf;
        tx_bit_tick = tx_ovf & tx_half_q;
        // RX phase cleared at start, so first overflow lands mid start bit
        rx_half_d = rx_start_seen ? 1'b0 : (rx_half_q ^ rx_ovf);
        rx_sample = rx_ovf & ~rx_half_q;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            presc_q   <= uap_pkg::PRE_RST;
            tx_tmr_q  <= uap_pkg::TMR_RST;
            rx_tmr_q  <= uap_pkg::TMR_RST;
            tx_half_q <= 1'b0;
            rx_half_q <= 1'b0;
        end
        else if (clk_en)
        begin
            presc_q   <= presc_d;
            tx_tmr_q  <= tx_tmr_d;
            rx_tmr_q  <= rx_tmr_d;
            tx_half_q <= tx_half_d;
            rx_half_q <= rx_half_d;
        end
    end

    // Transmit: two-entry buffer feeding the frame shifter
    logic [7:0]          buf_q [2];
    logic [7:0]          buf_d [2];
    logic                wr_ptr_q, wr_ptr_d;
    logic                rd_ptr_q, rd_ptr_d;
    logic [1:0]          cnt_q, cnt_d;
    logic                ready_q, ready_d;
    uap_pkg::uap_state_t tx_state_q, tx_state_d;
    logic [8:0]          tx_shift_q, tx_shift_d;
    logic [2:0]          tx_cnt_q, tx_cnt_d;
    logic                out_q, out_d;
    logic                tx_done_q, tx_done_d;
    logic                push;
    logic                pop;
    logic                tx_done_set;

    always_comb
    begin
        // Write goes to transmit side only
        push     = tx_wr_valid & ready_q;
        pop      = (tx_state_q == uap_pkg::ST_IDLE) & (cnt_q != uap_pkg::CNT_RST);
        buf_d    = buf_q;
        if (push)
        begin
            buf_d[wr_ptr_q] = tx_wr_data;
        end
        wr_ptr_d = wr_ptr_q ^ push;
        rd_ptr_d = rd_ptr_q ^ pop;
        cnt_d    = cnt_q + {1'b0, push} - {1'b0, pop};
        // Ready registered from next count so it never overstates room
        ready_d  = (cnt_d != uap_pkg::BUF_FULL);
        tx_state_d  = tx_state_q;
        tx_shift_d  = tx_shift_q;
        tx_cnt_d    = tx_cnt_q;
        out_d       = out_q;
        tx_done_set = 1'b0;
        unique case (tx_state_q)
            uap_pkg::ST_IDLE:
            begin
                if (pop)
                begin
                    // Ninth bit rides above the data
                    tx_shift_d = {ctrl.tx_ninth_bit, buf_q[rd_ptr_q]};
                    tx_state_d = uap_pkg::ST_START;
                end
            end
            uap_pkg::ST_START:
            begin
                if (tx_bit_tick)
                begin
                    out_d      = 1'b0;
                    tx_cnt_d   = uap_pkg::BIT_RST;
                    tx_state_d = uap_pkg::ST_DATA;
                end
            end
            uap_pkg::ST_DATA:
            begin
                if (tx_bit_tick)
                begin
                    out_d      = tx_shift_q[0];
                    tx_shift_d = {1'b1, tx_shift_q[8:1]};
                    tx_cnt_d   = tx_cnt_q + 3'h1;
                    if (tx_cnt_q == uap_pkg::LAST_BIT)
                    begin
                        tx_state_d = ctrl.word_length_select ? uap_pkg::ST_NINTH
                                                             : uap_pkg::ST_STOP;
                    end
                end
            end
            uap_pkg::ST_NINTH:
            begin
                if (tx_bit_tick)
                begin
                    out_d      = tx_shift_q[0];
                    tx_state_d = uap_pkg::ST_STOP;
                end
            end
            uap_pkg::ST_STOP:
            begin
                if (tx_bit_tick)
                begin
                    // Done at start of stop bit
                    out_d       = 1'b1;
                    tx_done_set = 1'b1;
                    tx_state_d  = uap_pkg::ST_IDLE;
                end
            end
        endcase
        tx_done_d = (tx_done_q & ~tx_done_clr) | tx_done_set;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buf_q[0]   <= 8'h00;
            buf_q[1]   <= 8'h00;
            wr_ptr_q   <= 1'b0;
            rd_ptr_q   <= 1'b0;
            cnt_q      <= uap_pkg::CNT_RST;
            ready_q    <= 1'b0;
            tx_state_q <= uap_pkg::ST_IDLE;
            tx_shift_q <= 9'h1FF;
            tx_cnt_q   <= uap_pkg::BIT_RST;
            out_q      <= 1'b1;
            tx_done_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            buf_q      <= buf_d;
            wr_ptr_q   <= wr_ptr_d;
            rd_ptr_q   <= rd_ptr_d;
            cnt_q      <= cnt_d;
            ready_q    <= ready_d;
            tx_state_q <= tx_state_d;
            tx_shift_q <= tx_shift_d;
            tx_cnt_q   <= tx_cnt_d;
            out_q      <= out_d;
            tx_done_q  <= tx_done_d;
        end
    end

    // Receive: shifter, buffered receive register, flag and interrupt
    logic [7:0] rx_shift_q, rx_shift_d;
    logic [2:0] rx_cnt_q, rx_cnt_d;
    logic       rx_b9_q, rx_b9_d;
    logic [7:0] rx_buf_q, rx_buf_d;
    logic       rx_nin_q, rx_nin_d;
    logic       rx_done_q, rx_done_d;
    logic       irq_q, irq_d;
    logic       rx_flag_bit;
    logic       rx_accept;

    always_comb
    begin
        rx_state_d = rx_state_q;
        rx_shift_d = rx_shift_q;
        rx_cnt_d   = rx_cnt_q;
        rx_b9_d    = rx_b9_q;
        rx_buf_d   = rx_buf_q;
        rx_nin_d   = rx_nin_q;
        // Ninth bit in 9-bit mode, stop bit otherwise
        rx_flag_bit = ctrl.word_length_select ? rx_b9_q : rx_bit;
        // Gate on flag clear and filter
        rx_accept  = ~rx_done_q & (~ctrl.multiproc_enable_bit | rx_flag_bit);
        unique case (rx_state_q)
            uap_pkg::ST_IDLE:
            begin
                if (rx_start_seen)
                begin
                    rx_state_d = uap_pkg::ST_START;
                end
            end
            uap_pkg::ST_START:
            begin
                if (rx_sample)
                begin
                    // Glitch shorter than half a bit is dropped
                    rx_cnt_d   = uap_pkg::BIT_RST;
                    rx_state_d = rx_bit ? uap_pkg::ST_IDLE : uap_pkg::ST_DATA;
                end
            end
            uap_pkg::ST_DATA:
            begin
                if (rx_sample)
                begin
                    rx_shift_d = {rx_bit, rx_shift_q[7:1]};
                    rx_cnt_d   = rx_cnt_q + 3'h1;
                    if (rx_cnt_q == uap_pkg::LAST_BIT)
                    begin
                        rx_state_d = ctrl.word_length_select ? uap_pkg::ST_NINTH
                                                             : uap_pkg::ST_STOP;
                    end
                end
            end
            uap_pkg::ST_NINTH:
            begin
                if (rx_sample)
                begin
                    rx_b9_d    = rx_bit;
                    rx_state_d = uap_pkg::ST_STOP;
                end
            end
            uap_pkg::ST_STOP:
            begin
                if (rx_sample)
                begin
                    // Shifter hands off to its own buffer
                    if (rx_accept)
                    begin
                        rx_buf_d = rx_shift_q;
                        rx_nin_d = rx_flag_bit;
                    end
                    rx_state_d = uap_pkg::ST_IDLE;
                end
            end
        endcase
        rx_done_d = (rx_done_q & ~rx_done_clr)
                    | ((rx_state_q == uap_pkg::ST_STOP) & rx_sample & rx_accept);
        // Level request while either flag is set
        irq_d = port_irq_enable & (tx_done_d | rx_done_d);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_state_q <= uap_pkg::ST_IDLE;
            rx_shift_q <= 8'h00;
            rx_cnt_q   <= uap_pkg::BIT_RST;
            rx_b9_q    <= 1'b0;
            rx_buf_q   <= 8'h00;
            rx_nin_q   <= 1'b0;
            rx_done_q  <= 1'b0;
            irq_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_state_q <= rx_state_d;
            rx_shift_q <= rx_shift_d;
            rx_cnt_q   <= rx_cnt_d;
            rx_b9_q    <= rx_b9_d;
            rx_buf_q   <= rx_buf_d;
            rx_nin_q   <= rx_nin_d;
            rx_done_q  <= rx_done_d;
            irq_q      <= irq_d;
        end
    end

    // Outputs, all from flops
    assign tx_wr_ready         = ready_q;
    assign serial_data_buffer  = rx_buf_q;
    assign rx_ninth_bit        = rx_nin_q;
    assign tx_done_flag        = tx_done_q;
    assign rx_done_flag        = rx_done_q;
    assign port_irq            = irq_q;
    assign baud_timer_low_byte = tx_tmr_q;
    assign serial_out_pin      = out_q;

endmodule

//--- test/uap_port_monitor.sv
// Port-level assertions for the async serial port
`timescale 1ns/1ps
module uap_port_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       clk_en,
    // Controls
    input wire logic       port_irq_enable,
    input wire logic       tx_done_clr,
    input wire logic       rx_done_clr,
    // Observed outputs
    input wire logic [7:0] serial_data_buffer,
    input wire logic       rx_ninth_bit,
    input wire logic       tx_done_flag,
    input wire logic       rx_done_flag,
    input wire logic       port_irq,
    input wire logic       serial_out_pin
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    AST_IRQ_LEVEL: assert property ($past(clk_en) |->
        port_irq == ($past(port_irq_enable) && (tx_done_flag || rx_done_flag)))
        else $error("port_irq disagrees with enabled flags");
    AST_TX_STICKY: assert property (tx_done_flag && !tx_done_clr |=> tx_done_flag)
        else $error("tx_done_flag dropped without clear");
    AST_RX_STICKY: assert property (rx_done_flag && !rx_done_clr |=> rx_done_flag)
        else $error("rx_done_flag dropped without clear");
    AST_TX_DONE_STOP: assert property ($rose(tx_done_flag) |-> serial_out_pin [*4])
        else $error("tx_done_flag not aligned to stop bit");
    AST_LOW_BIT: assert property ($fell(serial_out_pin) |-> (!serial_out_pin) [*4])
        else $error("low bit on serial_out_pin too short");
    AST_OVERRUN_KEEP: assert property (rx_done_flag |=>
        $stable(serial_data_buffer) && $stable(rx_ninth_bit))
        else $error("receive buffer overwritten while flag set");
    AST_BUF_LOAD: assert property ($changed(serial_data_buffer) |-> $rose(rx_done_flag))
        else $error("receive buffer loaded without flag");
    AST_NINTH_LOAD: assert property ($changed(rx_ninth_bit) |-> $rose(rx_done_flag))
        else $error("rx_ninth_bit loaded without flag");
endmodule

bind uap_serial_port uap_port_monitor uap_port_monitor_i (
    .clk, .resetn, .clk_en, .port_irq_enable, .tx_done_clr, .rx_done_clr,
    .serial_data_buffer, .rx_ninth_bit, .tx_done_flag, .rx_done_flag,
    .port_irq, .serial_out_pin
);

//--- test/uap_remote_node.sv
// Behavioural far-end serial node: frame sender and frame capturer
`timescale 1ns/1ps
module uap_remote_node (
    // Clock
    input  wire logic       clk,
    // Serial lines
    input  wire logic       line_in,
    output logic            line_out,
    // Frame shape
    input  wire logic       nine,
    input  wire logic [7:0] bit_cyc
);
    logic [9:0] got_q[$];
    logic [9:0] w;

    initial
        line_out = 1'b1;

    // start, data LSB first, ninth, stop
    task automatic send(input logic [7:0] d, input logic n9, input logic stp);
        logic [10:0] f;
        f = {stp, n9, d, 1'b0};
        if (!nine)
            f[9] = stp;
        for (int i = 0; i < (nine ? 11 : 10); i++)
        begin
            @(posedge clk);
            #1 line_out = f[i];
            repeat (bit_cyc - 1) @(posedge clk);
        end
        @(posedge clk);
        #1 line_out = 1'b1;
    endtask

    // Centre sampling; stop lands in bit 8 or 9
    always
    begin
        @(negedge line_in);
        repeat (bit_cyc / 2) @(posedge clk);
        w = 10'h000;
        for (int k = 0; k < (nine ? 10 : 9); k++)
        begin
            repeat (bit_cyc) @(posedge clk);
            w[k] = line_in;
        end
        got_q.push_back(w);
    end
endmodule

//--- test/testbench.sv
// Self-checking bench for the async serial port
`timescale 1ns/1ps
module testbench;
    logic               clk, resetn, clk_en, port_irq_enable, ok;
    logic               tx_done_clr, rx_done_clr, timer_enable;
    logic               ext_osc_pin, baud_timer_ext_input, serial_in_pin;
    logic               tx_wr_valid, tx_wr_ready, rx_ninth_bit, serial_out_pin;
    logic               tx_done_flag, rx_done_flag, port_irq;
    logic [7:0]         baud_reload_value, tx_wr_data, serial_data_buffer;
    logic [7:0]         baud_timer_low_byte, v, bit_cyc;
    logic [8:0]         last;
    logic [11:0]        row;
    uap_pkg::uap_ctrl_t ctrl;
    uap_pkg::uap_csel_t clk_sel;
    int                 n_fail, n_checks;
    logic [7:0]         bt[6] = '{8'h04, 8'h10, 8'h30, 8'hC0, 8'h40, 8'h10};
    logic [11:0]        rows[6] = '{12'h40F, 12'h5F0, 12'h0E1, 12'hD2D, 12'hED2, 12'h94B};
    logic [7:0]         seq[4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    uap_serial_port uap_serial_port_i (
        .clk, .resetn, .clk_en, .ctrl, .port_irq_enable, .tx_done_clr, .rx_done_clr,
        .timer_enable, .baud_reload_value, .clk_sel, .ext_osc_pin, .baud_timer_ext_input,
        .tx_wr_valid, .tx_wr_data, .tx_wr_ready, .serial_data_buffer, .rx_ninth_bit,
        .tx_done_flag, .rx_done_flag, .port_irq, .baud_timer_low_byte,
        .serial_in_pin, .serial_out_pin
    );

    uap_remote_node node_i (
        .clk, .line_in(serial_out_pin), .line_out(serial_in_pin),
        .nine(ctrl.word_length_select), .bit_cyc
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Oscillator pin rises every 2 cycles, timer pin falls every 4
    always @(posedge clk)
        #1 {baud_timer_ext_input, ext_osc_pin} = {baud_timer_ext_input, ext_osc_pin} + 2'h1;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Valid stays up so back-to-back writes never toggle it
    task automatic put(input logic [7:0] d);
        tx_wr_valid = 1'b1;
        tx_wr_data = d;
        while (!tx_wr_ready)
            tick(1);
        tick(1);
    endtask

    task automatic clr();
        {tx_done_clr, rx_done_clr} = 2'h3;
        tick(1);
        {tx_done_clr, rx_done_clr} = 2'h0;
    endtask

    task automatic got_frame(input logic [9:0] exp);
        for (int i = 0; i < 5000 && node_i.got_q.size() == 0; i++)
            tick(1);
        check(node_i.got_q.pop_front(), exp);
    endtask

    task automatic tx_chk(input logic [7:0] d, input logic [9:0] exp);
        put(d);
        tx_wr_valid = 1'b0;
        got_frame(exp);
        check(10'(tx_done_flag), 10'h1);
        tick(bit_cyc);
        clr();
    endtask

    task automatic rx_one(input logic [7:0] d, input logic n9, input logic stp);
        node_i.send(d, n9, stp);
        tick(2);
    endtask

    task automatic finish_test();
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    initial
    begin
        {clk_en, timer_enable, resetn} = 3'h6;
        ctrl = '0;
        {port_irq_enable, tx_done_clr, rx_done_clr, tx_wr_valid} = 4'h0;
        {baud_reload_value, tx_wr_data} = 16'hFE00;
        clk_sel = uap_pkg::CSEL_SYS;
        {baud_timer_ext_input, ext_osc_pin} = 2'h0;
        bit_cyc = 8'h04;
        n_fail = 0;
        n_checks = 0;
        tick(20);
        resetn = 1'b1;
        tick(2);
        // Bit time is 4 prescaler periods of the selected source at reload FE
        for (int s = 0; s < 6; s++)
        begin
            clk_sel = uap_pkg::uap_csel_t'(s);
            bit_cyc = bt[s];
            tx_chk(8'hA5 ^ 8'(s), {2'h1, 8'hA5 ^ 8'(s)});
        end
        baud_reload_value = 8'hFC;
        clk_sel = uap_pkg::CSEL_SYS;
        bit_cyc = 8'h08;
        ctrl.word_length_select = 1'b1;
        for (int n = 0; n < 2; n++)
        begin
            ctrl.tx_ninth_bit = n[0];
            tx_chk(8'h3C, {1'b1, n[0], 8'h3C});
        end
        ctrl = '0;
        for (int i = 0; i < 3; i++)
            put(seq[i]);
        tx_wr_valid = 1'b0;
        tick(2);
        check(10'(tx_wr_ready), 10'h0);
        put(seq[3]);
        tx_wr_valid = 1'b0;
        for (int i = 0; i < 4; i++)
            got_frame({2'h1, seq[i]});
        tick(bit_cyc);
        clr();
        // Written bytes never show on the read side
        check(10'(serial_data_buffer), 10'h000);
        for (int m = 0; m < 2; m++)
        begin
            {clk_en, timer_enable} = (m == 0) ? 2'h1 : 2'h2;
            v = baud_timer_low_byte;
            // Odd count, so a running four-value counter would move
            tick(13);
            check(10'(baud_timer_low_byte), 10'(v));
        end
        {clk_en, timer_enable} = 2'h3;
        port_irq_enable = 1'b1;
        rx_one(8'h5A, 1'b0, 1'b1);
        check(10'(rx_done_flag), 10'h0);
        ctrl.rx_enable_bit = 1'b1;
        rx_one(8'h5A, 1'b0, 1'b1);
        check({port_irq, rx_done_flag, serial_data_buffer}, 10'h35A);
        rx_one(8'hC3, 1'b0, 1'b1);
        check({port_irq, rx_done_flag, serial_data_buffer}, 10'h35A);
        clr();
        check(10'(port_irq), 10'h0);
        fork
            begin
                node_i.send(8'h96, 1'b0, 1'b1);
                node_i.send(8'h69, 1'b0, 1'b1);
            end
            begin
                for (int i = 0; i < 400 && rx_done_flag !== 1'b1; i++)
                    tick(1);
                // Read late, while the next frame is already arriving
                tick(20);
                check(10'(serial_data_buffer), 10'h096);
                clr();
            end
        join
        tick(2);
        check({rx_done_flag, serial_data_buffer}, 10'h169);
        clr();
        last = 9'h169;
        for (int r = 0; r < 6; r++)
        begin
            row = rows[r];
            ctrl = uap_pkg::uap_ctrl_t'({row[11], row[10], 2'h2});
            rx_one(row[7:0], row[9], row[8]);
            ok = !row[10] || (row[11] ? row[9] : row[8]);
            if (ok)
                last = {row[11] ? row[9] : row[8], row[7:0]};
            check({rx_done_flag, rx_ninth_bit, serial_data_buffer}, {ok, last});
            clr();
        end
        finish_test();
    end
endmodule
